// File: common/srnru_pkg.sv
// Shared constants, types and register map for the shift and nibble rotate unit.
`default_nettype none
package srnru_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the APB side.
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_GPR_LO = 8'h08;
	localparam logic [7:0] ADDR_GPR_HI = 8'h0C;
	localparam logic [7:0] ADDR_INDEX = 8'h10;
	localparam logic [7:0] ADDR_MEM_ADDR = 8'h14;
	localparam logic [7:0] ADDR_MEM_DATA = 8'h18;

	// Status word field positions.
	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	localparam int STS_ILLEGAL = 2;
	localparam int STS_MCYC_LO = 8;
	localparam int STS_TST_LO = 16;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_CMD = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode bytes and fields.
	localparam logic [7:0] OPC_CB = 8'hCB;
	localparam logic [7:0] OPC_DD = 8'hDD;
	localparam logic [7:0] OPC_FD = 8'hFD;
	localparam logic [7:0] OPC_ED = 8'hED;
	localparam logic [7:0] OPC_ARITH_MEM = 8'h2E;
	localparam logic [7:0] OPC_LOGIC_MEM = 8'h3E;
	localparam logic [7:0] OPC_NIB_L = 8'h6F;
	localparam logic [7:0] OPC_NIB_R = 8'h67;
	localparam logic [4:0] SHF_ARITH_HI = 5'h05;
	localparam logic [4:0] SHF_LOGIC_HI = 5'h07;
	localparam logic [2:0] RSEL_H = 3'h4;
	localparam logic [2:0] RSEL_L = 3'h5;
	localparam logic [2:0] RSEL_MEM = 3'h6;
	localparam logic [2:0] RSEL_A = 3'h7;

	// Flag bit positions inside the flag byte.
	localparam int FLG_S = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_H = 4;
	localparam int FLG_PV = 2;
	localparam int FLG_N = 1;
	localparam int FLG_C = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: clock states per machine cycle, first machine cycle in entry 0.
	localparam int unsigned TST_DIV = 2;
	localparam logic [5:0][2:0] TS_REG = {3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_MEM = {3'h0, 3'h0, 3'h3, 3'h4, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_IDX = {3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_NIB = {3'h0, 3'h3, 3'h4, 3'h3, 3'h4, 3'h4};
	localparam logic [2:0] MC_REG = 3'h2;
	localparam logic [2:0] MC_MEM = 3'h4;
	localparam logic [2:0] MC_IDX = 3'h6;
	localparam logic [2:0] MC_NIB = 3'h5;
	localparam logic [2:0] RDC_MEM = 3'h2;
	localparam logic [2:0] RDC_IDX = 3'h4;
	localparam logic [2:0] RDC_NIB = 3'h2;

	// Operand memory.
	localparam int MEM_AW = 8;
	localparam int MEM_DEPTH = 256;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {OPK_ARITH, OPK_LOGIC, OPK_NIB_L, OPK_NIB_R} srnru_op_e;
	typedef enum logic [1:0] {FORM_REG, FORM_MEM, FORM_IDX, FORM_NIB} srnru_form_e;
	typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_RUN} srnru_state_e;

	typedef struct packed {
		logic legal;
		srnru_op_e op;
		srnru_form_e form;
		logic [2:0] rsel;
		logic use_second;
		logic [7:0] disp;
	} srnru_instr_s;

endpackage : srnru_pkg
`default_nettype wire

// File: design/srnru_mem.sv
// Operand memory with registered read data.
`default_nettype none
module srnru_mem
	import srnru_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [MEM_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);

	logic [7:0] store [MEM_DEPTH];
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = store[addr];
	end

	always_ff @(posedge pclk)
	begin
		if (we)
		begin
			store[addr] <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata <= RST_BYTE;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

endmodule : srnru_mem
`default_nettype wire

// File: design/srnru_top.sv
// Shift right and nibble rotate execution unit with APB register access.
//
// Added by the designer: the APB register port and the register addresses.
`default_nettype none
module srnru_top
	import srnru_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	function automatic srnru_instr_s decode(input logic [31:0] cmd);
		srnru_instr_s d;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b3;
		d = '0;
		b0 = cmd[7:0];
		b1 = cmd[15:8];
		b3 = cmd[31:24];
		if (b0 == OPC_CB && (b1[7:3] == SHF_ARITH_HI || b1[7:3] == SHF_LOGIC_HI))
		begin
			d.legal = 1'b1;
			d.op = (b1[7:3] == SHF_LOGIC_HI) ? OPK_LOGIC : OPK_ARITH;
			d.rsel = b1[2:0];
			d.form = (b1[2:0] == RSEL_MEM) ? FORM_MEM : FORM_REG;
		end
		else if ((b0 == OPC_DD || b0 == OPC_FD) && b1 == OPC_CB
			&& (b3 == OPC_ARITH_MEM || b3 == OPC_LOGIC_MEM))
		begin
			d.legal = 1'b1;
			d.op = (b3 == OPC_LOGIC_MEM) ? OPK_LOGIC : OPK_ARITH;
			d.form = FORM_IDX;
			d.rsel = RSEL_MEM;
			d.use_second = (b0 == OPC_FD);
			d.disp = cmd[23:16];
		end
		else if (b0 == OPC_ED && (b1 == OPC_NIB_L || b1 == OPC_NIB_R))
		begin
			d.legal = 1'b1;
			d.op = (b1 == OPC_NIB_L) ? OPK_NIB_L : OPK_NIB_R;
			d.form = FORM_NIB;
			d.rsel = RSEL_MEM;
		end
		return d;
	endfunction : decode

	function automatic logic [2:0] m_len(input srnru_form_e f, input logic [2:0] i);
		logic [2:0] n;
		unique case (f)
			FORM_REG: n = TS_REG[i];
			FORM_MEM: n = TS_MEM[i];
			FORM_IDX: n = TS_IDX[i];
			FORM_NIB: n = TS_NIB[i];
		endcase
		return n;
	endfunction : m_len

	function automatic logic [2:0] m_cnt(input srnru_form_e f);
		logic [2:0] n;
		unique case (f)
			FORM_REG: n = MC_REG;
			FORM_MEM: n = MC_MEM;
			FORM_IDX: n = MC_IDX;
			FORM_NIB: n = MC_NIB;
		endcase
		return n;
	endfunction : m_cnt

	function automatic logic [2:0] rd_cyc(input srnru_form_e f);
		logic [2:0] n;
		unique case (f)
			FORM_REG: n = MC_REG;
			FORM_MEM: n = RDC_MEM;
			FORM_IDX: n = RDC_IDX;
			FORM_NIB: n = RDC_NIB;
		endcase
		return n;
	endfunction : rd_cyc

	// Half-carry and subtract stay zero because only the named flags are set.
	function automatic logic [7:0] mk_flags(input logic [7:0] v, input logic s_en,
		input logic c);
		logic [7:0] f;
		f = '0;
		f[FLG_S] = s_en & v[7];
		f[FLG_Z] = (v == RST_BYTE);
		f[FLG_PV] = ~^v;
		f[FLG_C] = c;
		return f;
	endfunction : mk_flags

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// State. Byte 6 of the register file holds the flags, since code 110 never selects it.

	srnru_state_e state, next_state;
	logic [31:0] cmd, next_cmd;
	srnru_instr_s instr, next_instr;
	logic [7:0][7:0] gpr, next_gpr;
	logic [15:0] ix, next_ix;
	logic [15:0] iy, next_iy;
	logic [7:0] mem_addr, next_mem_addr;
	logic [15:0] op_addr, next_op_addr;
	logic [2:0] mcyc, next_mcyc;
	logic [2:0] tcnt, next_tcnt;
	logic [2:0] mtot, next_mtot;
	logic [4:0] ttot, next_ttot;
	logic [3:0] tdiv, next_tdiv;
	logic done, next_done;
	logic illegal, next_illegal;
	logic [7:0] res, next_res;
	logic [7:0] res_acc, next_res_acc;
	logic [7:0] res_flg, next_res_flg;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	logic [7:0] mem_rdata;
	logic mem_we;
	logic [MEM_AW-1:0] mem_a;
	logic [7:0] mem_wdata;

	srnru_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.we(mem_we),
		.addr(mem_a),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Result computation from the current operand.

	logic [7:0] src, c_res, c_acc, c_flg;
	logic busy, t_en, acc;

	always_comb
	begin
		busy = (state != ST_IDLE);
		t_en = (tdiv == 4'(TST_DIV - 1));
		acc = psel & penable & ~pready;
		src = (instr.form == FORM_REG) ? gpr[instr.rsel] : mem_rdata;
		c_acc = gpr[RSEL_A];
		unique case (instr.op)
			OPK_ARITH:
			begin
				c_res = {src[7], src[7:1]};
				c_flg = mk_flags(c_res, 1'b1, src[0]);
			end
			OPK_LOGIC:
			begin
				c_res = {1'b0, src[7:1]};
				c_flg = mk_flags(c_res, 1'b0, src[0]);
			end
			OPK_NIB_L:
			begin
				c_res = {src[3:0], gpr[RSEL_A][3:0]};
				c_acc = {gpr[RSEL_A][7:4], src[7:4]};
				c_flg = mk_flags(c_acc, 1'b1, gpr[RSEL_MEM][FLG_C]);
			end
			OPK_NIB_R:
			begin
				c_res = {gpr[RSEL_A][3:0], src[7:4]};
				c_acc = {gpr[RSEL_A][7:4], src[3:0]};
				c_flg = mk_flags(c_acc, 1'b1, gpr[RSEL_MEM][FLG_C]);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer, register file and APB slave.

	always_comb
	begin
		next_state = state;
		next_cmd = cmd;
		next_instr = instr;
		next_gpr = gpr;
		next_ix = ix;
		next_iy = iy;
		next_mem_addr = mem_addr;
		next_op_addr = op_addr;
		next_mcyc = mcyc;
		next_tcnt = tcnt;
		next_mtot = mtot;
		next_ttot = ttot;
		next_tdiv = t_en ? 4'h0 : tdiv + 4'h1;
		next_done = done;
		next_illegal = illegal;
		next_res = res;
		next_res_acc = res_acc;
		next_res_flg = res_flg;
		next_prdata = prdata;
		next_pready = acc;
		next_pslverr = 1'b0;
		mem_we = 1'b0;
		mem_a = busy ? op_addr[MEM_AW-1:0] : mem_addr;
		mem_wdata = pwdata[7:0];

		unique case (state)
			ST_IDLE:
			begin
			end
			ST_DECODE:
			begin
				next_instr = decode(cmd);
				if (!next_instr.legal)
				begin
					next_illegal = 1'b1;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
				else
				begin
					if (next_instr.form == FORM_IDX)
					begin
						next_op_addr = (next_instr.use_second ? iy : ix)
							+ {{8{next_instr.disp[7]}}, next_instr.disp};
					end
					else
					begin
						next_op_addr = {gpr[RSEL_H], gpr[RSEL_L]};
					end
					next_state = ST_RUN;
				end
				next_tdiv = 4'h0;
				next_mcyc = 3'h0;
				next_tcnt = 3'h0;
			end
			ST_RUN:
			begin
				if (t_en)
				begin
					next_ttot = ttot + 5'h1;
					if (tcnt == m_len(instr.form, mcyc) - 3'h1)
					begin
						next_tcnt = 3'h0;
						next_mtot = mtot + 3'h1;
						next_mcyc = mcyc + 3'h1;
						if (mcyc == rd_cyc(instr.form))
						begin
							next_res = c_res;
							next_res_acc = c_acc;
							next_res_flg = c_flg;
						end
						if (mcyc == m_cnt(instr.form) - 3'h1)
						begin
							next_state = ST_IDLE;
							next_done = 1'b1;
							if (instr.form == FORM_REG)
							begin
								next_gpr[instr.rsel] = c_res;
								next_gpr[RSEL_MEM] = c_flg;
							end
							else
							begin
								mem_we = 1'b1;
								mem_wdata = res;
								next_gpr[RSEL_MEM] = res_flg;
								if (instr.form == FORM_NIB)
								begin
									next_gpr[RSEL_A] = res_acc;
								end
							end
						end
					end
					else
					begin
						next_tcnt = tcnt + 3'h1;
					end
				end
			end
		endcase

		if (acc)
		begin
			if (pwrite)
			begin
				if (busy || paddr == ADDR_STATUS)
				begin
					next_pslverr = 1'b1;
				end
				else
				begin
					unique case (paddr)
						ADDR_CMD:
						begin
							next_cmd = merge(cmd, pwdata, pstrb);
							next_state = ST_DECODE;
							next_done = 1'b0;
							next_illegal = 1'b0;
							next_mtot = 3'h0;
							next_ttot = 5'h0;
						end
						ADDR_GPR_LO:
						begin
							{next_gpr[0], next_gpr[1], next_gpr[2], next_gpr[3]} =
								merge({gpr[0], gpr[1], gpr[2], gpr[3]}, pwdata, pstrb);
						end
						ADDR_GPR_HI:
						begin
							{next_gpr[RSEL_H], next_gpr[RSEL_L], next_gpr[RSEL_A],
								next_gpr[RSEL_MEM]} = merge({gpr[RSEL_H], gpr[RSEL_L],
								gpr[RSEL_A], gpr[RSEL_MEM]}, pwdata, pstrb);
						end
						ADDR_INDEX:
						begin
							{next_iy, next_ix} = merge({iy, ix}, pwdata, pstrb);
						end
						ADDR_MEM_ADDR:
						begin
							next_mem_addr = pstrb[0] ? pwdata[7:0] : mem_addr;
						end
						ADDR_MEM_DATA:
						begin
							mem_we = pstrb[0];
						end
						default:
						begin
							next_pslverr = 1'b1;
						end
					endcase
				end
			end
			else
			begin
				next_prdata = '0;
				unique case (paddr)
					ADDR_CMD: next_prdata = cmd;
					ADDR_STATUS:
					begin
						next_prdata[STS_BUSY] = busy;
						next_prdata[STS_DONE] = done;
						next_prdata[STS_ILLEGAL] = illegal;
						next_prdata[STS_MCYC_LO +: 3] = mtot;
						next_prdata[STS_TST_LO +: 5] = ttot;
					end
					ADDR_GPR_LO: next_prdata = {gpr[0], gpr[1], gpr[2], gpr[3]};
					ADDR_GPR_HI:
					begin
						next_prdata = {gpr[RSEL_H], gpr[RSEL_L], gpr[RSEL_A], gpr[RSEL_MEM]};
					end
					ADDR_INDEX: next_prdata = {iy, ix};
					ADDR_MEM_ADDR: next_prdata[7:0] = mem_addr;
					ADDR_MEM_DATA:
					begin
						if (busy)
						begin
							next_pslverr = 1'b1;
						end
						else
						begin
							next_prdata[7:0] = mem_rdata;
						end
					end
					default: next_pslverr = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			cmd <= RST_CMD;
			instr <= '0;
			gpr <= '0;
			ix <= RST_WORD;
			iy <= RST_WORD;
			mem_addr <= RST_BYTE;
			op_addr <= RST_WORD;
			mcyc <= 3'h0;
			tcnt <= 3'h0;
			mtot <= 3'h0;
			ttot <= 5'h00;
			tdiv <= 4'h0;
			done <= 1'b0;
			illegal <= 1'b0;
			res <= RST_BYTE;
			res_acc <= RST_BYTE;
			res_flg <= RST_BYTE;
			prdata <= RST_CMD;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cmd <= next_cmd;
			instr <= next_instr;
			gpr <= next_gpr;
			ix <= next_ix;
			iy <= next_iy;
			mem_addr <= next_mem_addr;
			op_addr <= next_op_addr;
			mcyc <= next_mcyc;
			tcnt <= next_tcnt;
			mtot <= next_mtot;
			ttot <= next_ttot;
			tdiv <= next_tdiv;
			done <= next_done;
			illegal <= next_illegal;
			res <= next_res;
			res_acc <= next_res_acc;
			res_flg <= next_res_flg;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

endmodule : srnru_top
`default_nettype wire

// File: testbench/srnru_chk.sv
// Checker for the shift and nibble rotate unit, bound to its top module.
`default_nettype none
module srnru_chk
	import srnru_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] cmd, next_cmd;
	logic [7:0] cyc, next_cyc;
	logic seen, next_seen;
	logic rd, is_reg, is_mem, is_idx, is_nib, dn, ill;
	////////////////////////////////////////////////////////////////////////////////
	// Remembers the low 16 bits of the last accepted command word and counts cycles since its answer.
	// A command refused while busy must not restart the count of the running one.
	always_comb
	begin
		next_cmd = cmd;
		next_cyc = (cyc == 8'hFF) ? cyc : cyc + 8'h01;
		next_seen = seen;
		if (psel && penable && pwrite && pready && !pslverr && paddr == ADDR_CMD)
		begin
			next_cmd = pwdata[15:0];
			next_cyc = 8'h00;
			next_seen = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd <= 16'h0000;
			cyc <= 8'h00;
			seen <= 1'b0;
		end
		else
		begin
			cmd <= next_cmd;
			cyc <= next_cyc;
			seen <= next_seen;
		end
	end
	assign rd = pready && psel && penable && !pwrite && paddr == ADDR_STATUS && !pslverr;
	assign is_reg = cmd[7:0] == OPC_CB && cmd[10:8] != RSEL_MEM
		&& (cmd[15:11] == SHF_ARITH_HI || cmd[15:11] == SHF_LOGIC_HI);
	assign is_mem = cmd[7:0] == OPC_CB && (cmd[15:8] == OPC_ARITH_MEM || cmd[15:8] == OPC_LOGIC_MEM);
	assign is_idx = (cmd[7:0] == OPC_DD || cmd[7:0] == OPC_FD) && cmd[15:8] == OPC_CB;
	assign is_nib = cmd[7:0] == OPC_ED && (cmd[15:8] == OPC_NIB_L || cmd[15:8] == OPC_NIB_R);
	assign dn = prdata[STS_DONE] && !prdata[STS_ILLEGAL];
	assign ill = prdata[STS_ILLEGAL];
	////////////////////////////////////////////////////////////////////////////////
	a_reg_timing: assert property (rd && is_reg && dn |->
		prdata[STS_TST_LO +: 5] == 5'h08 && prdata[STS_MCYC_LO +: 3] == 3'h2)
		else $error("register shift totals wrong");
	a_mem_timing: assert property (rd && is_mem && dn |->
		prdata[STS_TST_LO +: 5] == 5'h0F && prdata[STS_MCYC_LO +: 3] == 3'h4)
		else $error("pointer pair shift totals wrong");
	a_idx_timing: assert property (rd && is_idx && dn |->
		prdata[STS_TST_LO +: 5] == 5'h17 && prdata[STS_MCYC_LO +: 3] == 3'h6)
		else $error("indexed shift totals wrong");
	a_nib_timing: assert property (rd && is_nib && dn |->
		prdata[STS_TST_LO +: 5] == 5'h12 && prdata[STS_MCYC_LO +: 3] == 3'h5)
		else $error("nibble rotate totals wrong");
	a_reg_busy: assert property (rd && is_reg && cyc inside {[8'h03:8'h0C]} |->
		prdata[STS_BUSY] && !prdata[STS_DONE]) else $error("register shift ended early");
	a_nib_busy: assert property (rd && is_nib && cyc inside {[8'h03:8'h1E]} |->
		prdata[STS_BUSY] && !prdata[STS_DONE]) else $error("nibble rotate ended early");
	a_done_late: assert property (rd && seen && cyc >= 8'h3C |->
		prdata[STS_DONE] && !prdata[STS_BUSY]) else $error("instruction never finished");
	a_illegal_idle: assert property (rd && ill |-> prdata[STS_DONE] &&
		prdata[STS_TST_LO +: 5] == 5'h00 && prdata[STS_MCYC_LO +: 3] == 3'h0)
		else $error("refused command counted cycles");
	c_idx_done: cover property (rd && is_idx && dn);
	c_nib_done: cover property (rd && is_nib && dn);
	c_illegal: cover property (rd && ill);
endmodule : srnru_chk
bind srnru_top srnru_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: testbench/srnru_bfm.sv
// Bus master that stands in for the instruction sequencer in front of the unit.
`default_nettype none
module srnru_bfm
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
	end
	// Released address and data lines are inverted so stale values are never read.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : srnru_bfm
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking testbench for the shift and nibble rotate unit.
`default_nettype none
module testbench
	import srnru_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} srnru_note_s;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, v, m, a, ad, dsp;
	logic [31:0] pwdata, prdata, iw, c;
	logic [3:0] pstrb;
	logic [2:0] kn;
	logic [7:0] rf [0:7];
	srnru_note_s notes[$];
	srnru_note_s n;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	srnru_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	srnru_bfm i_bfm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	always #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] flg(input logic [7:0] r, input logic cy);
		return {r[7], r == 8'h00, 3'h0, ~^r, 1'b0, cy};
	endfunction : flg
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic xf(input logic w, input logic [7:0] ar, input logic [31:0] d,
		input logic [31:0] mk, input logic e, output logic [31:0] r);
		notes.push_back({w ? 32'h0 : d, mk, e});
		i_bfm.xfer(w, ar, d, r);
	endtask : xf
	task automatic wr(input logic [7:0] ar, input logic [31:0] d, input logic e);
		logic [31:0] r;
		xf(1'b1, ar, d, 32'h0, e, r);
	endtask : wr
	task automatic rd(input logic [7:0] ar, input logic [31:0] d, input logic [31:0] mk,
		input logic e);
		logic [31:0] r;
		xf(1'b0, ar, d, mk, e, r);
	endtask : rd
	task automatic wt;
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 40 && s[STS_DONE] !== 1'b1; i++)
			xf(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0, s);
	endtask : wt
	task automatic ld;
		for (int j = 0; j < 8; j++)
			rf[j] = 8'($urandom());
		wr(ADDR_GPR_LO, {rf[0], rf[1], rf[2], rf[3]}, 1'b0);
	endtask : ld
	task automatic vf;
		rd(ADDR_GPR_LO, {rf[0], rf[1], rf[2], rf[3]}, 32'hFFFF_FFFF, 1'b0);
		rd(ADDR_GPR_HI, {rf[4], rf[5], rf[7], rf[6]}, 32'hFFFF_FFD7, 1'b0);
	endtask : vf
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && notes.size() > 0)
		begin
			n = notes.pop_front();
			check(prdata & n.m, n.d & n.m);
			check({31'h0, pslverr}, {31'h0, n.e});
		end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			test_done;
		end
	end
	initial
	begin
		presetn = 1'b0;
		void'($urandom(32'hCACB));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			if (k[2:0] == RSEL_MEM)
				continue;
			ld;
			if (k[2:0] == 3'h1)
				rf[1] = k[3] ? 8'h80 : 8'h01;
			wr(ADDR_GPR_LO, {rf[0], rf[1], rf[2], rf[3]}, 1'b0);
			wr(ADDR_GPR_HI, {rf[4], rf[5], rf[7], rf[6]}, 1'b0);
			wr(ADDR_CMD, {16'h0, k[3] ? SHF_LOGIC_HI : SHF_ARITH_HI, k[2:0], OPC_CB}, 1'b0);
			wt;
			v = rf[k[2:0]];
			rf[k[2:0]] = {k[3] ? 1'b0 : v[7], v[7:1]};
			rf[6] = flg(rf[k[2:0]], v[0]);
			vf;
		end
		$display("Test register shifts done");
		for (int k = 0; k < 12; k++)
		begin
			kn = 3'(k % 6);
			ld;
			wr(ADDR_GPR_HI, {rf[4], rf[5], rf[7], rf[6]}, 1'b0);
			iw = $urandom();
			dsp = 8'($urandom());
			m = 8'($urandom());
			ad = kn == 3'h2 ? iw[7:0] + dsp : (kn == 3'h3 ? iw[23:16] + dsp : rf[5]);
			wr(ADDR_INDEX, iw, 1'b0);
			rd(ADDR_INDEX, iw, 32'hFFFF_FFFF, 1'b0);
			wr(ADDR_MEM_ADDR, {24'h0, ad}, 1'b0);
			rd(ADDR_MEM_ADDR, {24'h0, ad}, 32'hFFFF_FFFF, 1'b0);
			wr(ADDR_MEM_DATA, {24'h0, m}, 1'b0);
			case (kn)
				3'h0: c = {16'h0, OPC_ARITH_MEM, OPC_CB};
				3'h1: c = {16'h0, OPC_LOGIC_MEM, OPC_CB};
				3'h2: c = {OPC_ARITH_MEM, dsp, OPC_CB, OPC_DD};
				3'h3: c = {OPC_LOGIC_MEM, dsp, OPC_CB, OPC_FD};
				3'h4: c = {16'h0, OPC_NIB_L, OPC_ED};
				default: c = {16'h0, OPC_NIB_R, OPC_ED};
			endcase
			wr(ADDR_CMD, c, 1'b0);
			if (k == 5)
			begin
				wr(ADDR_CMD, c, 1'b1);
				rd(ADDR_MEM_DATA, 32'h0, 32'h0, 1'b1);
			end
			wt;
			rd(ADDR_CMD, c, 32'hFFFF_FFFF, 1'b0);
			if (kn < 3'h4)
			begin
				v = {kn[0] ? 1'b0 : m[7], m[7:1]};
				rf[6] = flg(v, m[0]);
				m = v;
			end
			else
			begin
				a = rf[7];
				rf[7] = {a[7:4], kn[0] ? m[3:0] : m[7:4]};
				m = kn[0] ? {a[3:0], m[7:4]} : {m[3:0], a[3:0]};
				rf[6] = flg(rf[7], rf[6][0]);
			end
			rd(ADDR_MEM_DATA, {24'h0, m}, 32'h0000_00FF, 1'b0);
			vf;
		end
		$display("Test memory forms done");
		repeat (60) @(posedge pclk);
		rd(ADDR_STATUS, 32'h2, 32'h7, 1'b0);
		rd(8'h1C, 32'h0, 32'h0, 1'b1);
		wr(ADDR_STATUS, 32'h0, 1'b1);
		wr(ADDR_CMD, {8'h2F, 8'h05, OPC_CB, OPC_DD}, 1'b0);
		rd(ADDR_STATUS, 32'h6, 32'h001F_0707, 1'b0);
		vf;
		$display("Test refusals done");
		test_done;
	end
endmodule : testbench
`default_nettype wire
